// ==== bench/pic_loader.sv ====
// loader model: writes each sixteen-bit count as two byte strobes
`timescale 1ns/100ps
`default_nettype none
module pic_loader (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic req,
  input wire logic [15:0] val,
  output logic [7:0] load_byte,
  output logic load_stb
);
  // ==========================================================
  // byte sequencer
  logic hi_reg;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      hi_reg <= 1'b0;
      load_stb <= 1'b0;
      load_byte <= 8'h00;
    end else begin
      load_stb <= req | hi_reg;
      // idle bus toggles so a stale byte is never mistaken for data
      load_byte <= hi_reg ? val[15:8] : (req ? val[7:0] : ~load_byte);
      hi_reg <= req & ~hi_reg;
    end
  end
endmodule : pic_loader
`default_nettype wire

// ==== bench/programmable_interval_counter_tb.sv ====
// testbench for the programmable interval counter
`timescale 1ns/100ps
`default_nettype none
module programmable_interval_counter_tb;
  import pic_pkg::*;
  logic clk_sys = 1'b0, reset_n = 1'b0, cnt_clk_pin = 1'b0, gate_pin = 1'b0, req = 1'b0;
  logic [2:0] mode_sel = 3'h0;
  logic [15:0] val = 16'h0000;
  logic [7:0] load_byte;
  logic load_stb, out_pin, load_done;
  int error_cnt = 0, n_tests = 0;
  pic_loader ldr (.clk_sys(clk_sys), .reset_n(reset_n), .req(req), .val(val), .load_byte(load_byte),
    .load_stb(load_stb));
  pic_counter uut (.clk_sys(clk_sys), .reset_n(reset_n), .cnt_clk_pin(cnt_clk_pin), .gate_pin(gate_pin),
    .mode_sel(mode_sel), .load_byte(load_byte), .load_stb(load_stb), .out_pin(out_pin), .load_done(load_done));
  initial forever #4 clk_sys = ~clk_sys;
  // ==========================================================
  // helpers
  task automatic stop_test();
    $display("tests %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : stop_test
  task automatic chk(string what, logic exp, logic got);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %b seen %b", what, exp, got);
    end
  endtask : chk
  task automatic chk_n(string what, int exp, int got);
    n_tests++;
    if (got != exp) begin
      error_cnt++;
      $display("mismatch %s expected %0d seen %0d", what, exp, got);
    end
  endtask : chk_n
  task automatic wt(int n);
    repeat (n) @(posedge clk_sys);
  endtask : wt
  // pin phases of 3 and 4 cycles leave room for the two-stage sync
  task automatic tick();
    cnt_clk_pin <= 1'b1;
    wt(3);
    cnt_clk_pin <= 1'b0;
    wt(4);
  endtask : tick
  task automatic gate(logic v);
    gate_pin <= v;
    wt(6);
  endtask : gate
  task automatic load(logic [2:0] m, logic [15:0] n);
    int i;
    mode_sel <= m;
    val <= n;
    req <= 1'b1;
    wt(1);
    req <= 1'b0;
    for (i = 0; i < 8 && load_done !== 1'b1; i++) wt(1);
    chk("load_done", 1'b1, load_done);
    if (i == 8) stop_test();
    wt(1);
    chk("load_done width", 1'b0, load_done);
    wt(1);
  endtask : load
  task automatic run(int t, int lows, int maxrun);
    int lo, r, mx;
    lo = 0;
    r = 0;
    mx = 0;
    repeat (t) begin
      tick();
      r = (out_pin === 1'b0) ? r + 1 : 0;
      lo += (out_pin === 1'b0);
      mx = (r > mx) ? r : mx;
    end
    chk_n("low ticks", lows, lo);
    chk_n("low run", maxrun, mx);
  endtask : run
  // ==========================================================
  // scenarios
  // reset after a load but before any trigger, then the smallest count
  task automatic test_reset();
    load(3'h0, 16'h0003);
    chk("rst loaded", 1'b0, out_pin);
    reset_n <= 1'b0;
    wt(2);
    chk("rst out", PIC_OUT_RESET, out_pin);
    chk("rst done", 1'b0, load_done);
    reset_n <= 1'b1;
    wt(2);
    chk("rst release", PIC_OUT_RESET, out_pin);
    load(3'h0, 16'h0001);
    chk("rst reload", 1'b0, out_pin);
    gate(1'b1);
    tick();
    chk("m0 count one", 1'b1, out_pin);
    gate(1'b0);
  endtask : test_reset
  task automatic test_mode0();
    load(3'h0, 16'h0003);
    chk("m0 loaded", 1'b0, out_pin);
    repeat (4) tick();
    chk("m0 untriggered", 1'b0, out_pin);
    gate(1'b1);
    repeat (2) tick();
    chk("m0 counting", 1'b0, out_pin);
    tick();
    chk("m0 zero", 1'b1, out_pin);
    tick();
    chk("m0 hold", 1'b1, out_pin);
  endtask : test_mode0
  task automatic test_mode4();
    load(3'h4, 16'h0002);
    chk("m4 loaded", 1'b1, out_pin);
    gate(1'b0);
    repeat (2) tick();
    chk("m4 gate low", 1'b1, out_pin);
    gate(1'b1);
    tick();
    chk("m4 one", 1'b1, out_pin);
    run(4, 1, 1);
  endtask : test_mode4
  task automatic test_mode2();
    gate(1'b0);
    load(3'h2, 16'h0003);
    gate(1'b1);
    tick();
    run(9, 3, 1);
    gate(1'b0);
    chk("m2 stop", 1'b1, out_pin);
    run(6, 0, 0);
  endtask : test_mode2
  task automatic test_mode3();
    load(3'h3, 16'h0005);
    gate(1'b1);
    tick();
    run(10, 4, 2);
  endtask : test_mode3
  task automatic test_mode1();
    gate(1'b0);
    load(3'h1, 16'h0003);
    gate(1'b1);
    tick();
    chk("m1 start", 1'b0, out_pin);
    tick();
    gate(1'b0);
    gate(1'b1);
    repeat (3) tick();
    chk("m1 stretched", 1'b0, out_pin);
    tick();
    chk("m1 end", 1'b1, out_pin);
  endtask : test_mode1
  task automatic test_mode5();
    gate(1'b0);
    load(3'h5, 16'h0002);
    gate(1'b1);
    run(4, 1, 1);
    gate(1'b0);
    gate(1'b1);
    tick();
    gate(1'b0);
    gate(1'b1);
    run(2, 0, 0);
    run(2, 1, 1);
  endtask : test_mode5
  initial begin
    wt(20);
    reset_n <= 1'b1;
    wt(2);
    chk("out reset", PIC_OUT_RESET, out_pin);
    test_reset();
    test_mode0();
    test_mode4();
    test_mode2();
    test_mode3();
    test_mode1();
    test_mode5();
    stop_test();
  end
endmodule : programmable_interval_counter_tb
`default_nettype wire

// ==== verilog/pic_counter.sv ====
// programmable interval counter with six counting modes
`timescale 1ns/100ps
`default_nettype none
module pic_counter import pic_pkg::*; (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic cnt_clk_pin,
  input wire logic gate_pin,
  input wire logic [2:0] mode_sel,
  input wire logic [7:0] load_byte,
  input wire logic load_stb,
  output logic out_pin,
  output logic load_done
);
  // ==========================================================
  // pin synchronisers
  logic clk_s1_reg, clk_s2_reg, clk_d_reg;
  logic gate_s1_reg, gate_s2_reg, gate_d_reg;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      clk_s1_reg <= 1'b0;
      clk_s2_reg <= 1'b0;
      clk_d_reg <= 1'b0;
      gate_s1_reg <= 1'b0;
      gate_s2_reg <= 1'b0;
      gate_d_reg <= 1'b0;
    end else begin
      clk_s1_reg <= cnt_clk_pin;
      clk_s2_reg <= clk_s1_reg;
      clk_d_reg <= clk_s2_reg;
      gate_s1_reg <= gate_pin;
      gate_s2_reg <= gate_s1_reg;
      gate_d_reg <= gate_s2_reg;
    end
  end

  logic tick, gate_rise, gate_hi;
  assign tick = clk_s2_reg & ~clk_d_reg;
  assign gate_rise = gate_s2_reg & ~gate_d_reg;
  assign gate_hi = gate_s2_reg;

  pic_mode_t mode;
  assign mode = pic_mode_t'(mode_sel);

  // ==========================================================
  // byte loader: low byte is held until the high byte arrives
  logic hi_sel_reg, load_done_reg;
  logic [7:0] low_byte_reg;
  logic [15:0] init_reg;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      hi_sel_reg <= 1'b0;
      low_byte_reg <= PIC_BYTE_RESET;
      init_reg <= {PIC_BYTE_RESET, PIC_BYTE_RESET};
      load_done_reg <= 1'b0;
    end else begin
      load_done_reg <= 1'b0;
      if (load_stb) begin
        hi_sel_reg <= ~hi_sel_reg;
        if (!hi_sel_reg) begin
          low_byte_reg <= load_byte;
        end else begin
          init_reg <= {load_byte, low_byte_reg};
          load_done_reg <= 1'b1;
        end
      end
    end
  end
  assign load_done = load_done_reg;

  // a written zero stands for the largest count
  logic [16:0] init_full;
  assign init_full = (init_reg == 16'h0000) ? PIC_FULL_COUNT : {1'b0, init_reg};

  // ==========================================================
  // trigger capture; an edge in the cycle it is consumed survives
  logic trig_pend_reg, trig_use;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      trig_pend_reg <= 1'b0;
    end else if (gate_rise) begin
      trig_pend_reg <= 1'b1;
    end else if (trig_use) begin
      trig_pend_reg <= 1'b0;
    end
  end

  // ==========================================================
  // counting core
  logic [16:0] count_reg;
  logic run_reg, out_reg, armed_reg;
  assign trig_use = trig_pend_reg & (load_done_reg | tick);

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      count_reg <= PIC_CNT_RESET;
      run_reg <= 1'b0;
      armed_reg <= 1'b0;
      out_reg <= PIC_OUT_RESET;
    end else if (load_done_reg) begin
      count_reg <= init_full;
      armed_reg <= 1'b1;
      case (mode)
        PIC_MODE_TERM: begin
          out_reg <= 1'b0;
          run_reg <= 1'b0;
        end
        PIC_MODE_SWSTB: begin
          out_reg <= 1'b1;
          run_reg <= 1'b1;
        end
        default: begin
          out_reg <= 1'b1;
          run_reg <= 1'b0;
        end
      endcase
    end else begin
      case (mode)
        PIC_MODE_TERM: begin
          if (trig_pend_reg && armed_reg && !run_reg && !out_reg) begin
            run_reg <= 1'b1;
          end else if (run_reg && tick) begin
            count_reg <= count_reg - PIC_STEP_ONE;
            if (count_reg == PIC_STEP_ONE) begin
              out_reg <= 1'b1;
              run_reg <= 1'b0;
            end
          end
        end
        PIC_MODE_ONESHOT, PIC_MODE_HWSTB: begin
          if (tick && trig_pend_reg && armed_reg) begin
            count_reg <= init_full;
            run_reg <= 1'b1;
            out_reg <= (mode == PIC_MODE_HWSTB);
          end else if (tick) begin
            if (mode == PIC_MODE_HWSTB && !out_reg) begin
              out_reg <= 1'b1;
            end
            if (run_reg) begin
              count_reg <= count_reg - PIC_STEP_ONE;
              if (count_reg == PIC_STEP_ONE) begin
                run_reg <= 1'b0;
                out_reg <= (mode == PIC_MODE_ONESHOT);
              end
            end
          end
        end
        PIC_MODE_RATE, PIC_MODE_SQUARE: begin
          if (!gate_hi) begin
            run_reg <= 1'b0;
            out_reg <= 1'b1;
          end else if (tick && trig_pend_reg && armed_reg) begin
            count_reg <= init_full;
            run_reg <= 1'b1;
            out_reg <= 1'b1;
          end else if (tick && run_reg) begin
            if (mode == PIC_MODE_RATE) begin
              if (count_reg == PIC_STEP_ONE) begin
                count_reg <= init_full;
                out_reg <= 1'b1;
              end else begin
                count_reg <= count_reg - PIC_STEP_ONE;
                out_reg <= (count_reg != PIC_STEP_TWO);
              end
            end else if (count_reg <= PIC_STEP_TWO) begin
              // odd counts give the low half one count less
              out_reg <= ~out_reg;
              count_reg <= out_reg ? {init_full[16:1], 1'b0} : init_full;
            end else begin
              count_reg <= count_reg - PIC_STEP_TWO;
            end
          end
        end
        PIC_MODE_SWSTB: begin
          if (tick && !out_reg) begin
            out_reg <= 1'b1;
          end else if (tick && run_reg && gate_hi) begin
            count_reg <= count_reg - PIC_STEP_ONE;
            if (count_reg == PIC_STEP_ONE) begin
              out_reg <= 1'b0;
              run_reg <= 1'b0;
            end
          end
        end
        default: begin
          run_reg <= 1'b0;
        end
      endcase
    end
  end
  assign out_pin = out_reg;

  // ==========================================================
  // checks
  sequence s_low_then_high;
    !out_reg ##1 out_reg;
  endsequence

  a_byte_pair: assert property (@(posedge clk_sys) disable iff (!reset_n)
    load_stb && hi_sel_reg |=> load_done_reg ##1 !load_done_reg)
    else $error("count not applied after high byte");
  a_mode0_load_low: assert property (@(posedge clk_sys) disable iff (!reset_n)
    load_done_reg && mode == PIC_MODE_TERM |=> !out_reg && !run_reg)
    else $error("mode 0 load did not drive output low");
  a_mode0_wait_trig: assert property (@(posedge clk_sys) disable iff (!reset_n)
    mode == PIC_MODE_TERM && !run_reg && !load_done_reg && $stable(mode) |=> $stable(count_reg))
    else $error("mode 0 counted without trigger");
  a_mode0_terminal: assert property (@(posedge clk_sys) disable iff (!reset_n)
    mode == PIC_MODE_TERM && run_reg && tick && count_reg == PIC_STEP_ONE && !load_done_reg |=> out_reg)
    else $error("mode 0 output not high at zero");
  a_oneshot_start: assert property (@(posedge clk_sys) disable iff (!reset_n)
    mode == PIC_MODE_ONESHOT && tick && trig_pend_reg && armed_reg && !load_done_reg
    |=> !out_reg && count_reg == init_full)
    else $error("one-shot did not start after trigger");
  a_rate_pulse: assert property (@(posedge clk_sys) disable iff (!reset_n)
    mode == PIC_MODE_RATE && gate_hi && run_reg && tick && count_reg == PIC_STEP_TWO && !load_done_reg
    && !trig_pend_reg |=> !out_reg)
    else $error("rate pulse missing");
  a_gate_stop: assert property (@(posedge clk_sys) disable iff (!reset_n)
    mode == PIC_MODE_RATE && !gate_hi && !load_done_reg |=> !run_reg && out_reg)
    else $error("rate mode ran with gate low");
  a_square_step: assert property (@(posedge clk_sys) disable iff (!reset_n)
    mode == PIC_MODE_SQUARE && gate_hi && run_reg && tick && !trig_pend_reg && !load_done_reg
    && count_reg > PIC_STEP_TWO |=> count_reg == $past(count_reg) - PIC_STEP_TWO)
    else $error("square wave did not step by two");
  a_strobe_inhibit: assert property (@(posedge clk_sys) disable iff (!reset_n)
    mode == PIC_MODE_SWSTB && !gate_hi && !load_done_reg && $stable(mode) |=> $stable(count_reg))
    else $error("strobe counted with gate low");
  a_strobe_one_low: assert property (@(posedge clk_sys) disable iff (!reset_n)
    mode == PIC_MODE_SWSTB && !out_reg && !load_done_reg |=> out_reg == $past(tick))
    else $error("strobe low not one period");
  a_trig_capture: assert property (@(posedge clk_sys) disable iff (!reset_n)
    gate_rise |=> trig_pend_reg)
    else $error("trigger edge lost");
  a_hw_strobe: assert property (@(posedge clk_sys) disable iff (!reset_n)
    mode == PIC_MODE_HWSTB && run_reg && tick && count_reg == PIC_STEP_ONE && !trig_pend_reg
    && !load_done_reg |=> s_low_then_high or (!out_reg ##1 !out_reg))
    else $error("hardware strobe pulse missing");
endmodule : pic_counter
`default_nettype wire

// ==== verilog/pic_pkg.sv ====
// package of constants and types for the programmable interval counter
// ==========================================================
// Operation
// - sixteen-bit down-counter, counts one to 65536
// - count on clock pulses, gate rise triggers
// - mode 0: low after load until zero
// - mode 0: decrement only after a trigger
// - mode 1: low after trigger until zero
// - mode 1: retrigger reloads and stretches pulse
// - mode 2: divide by N, one-period low pulse
// - mode 2: repeats while gate high, stops low
// - mode 3: high (N+1)/2, low (N-1)/2 counts for odd N, N/2 each for even N
// - mode 3: step by two each half
// - mode 4: count on load, one low pulse
// - mode 4: low gate suspends counting
// - mode 5: trigger starts, one low pulse
// - mode 5: retrigger restarts the full count
`default_nettype none
package pic_pkg;
  localparam int PIC_CNT_W = 17;
  localparam logic [16:0] PIC_FULL_COUNT = 17'h10000;
  localparam logic [16:0] PIC_CNT_RESET = 17'h00000;
  localparam logic [16:0] PIC_STEP_ONE = 17'h00001;
  localparam logic [16:0] PIC_STEP_TWO = 17'h00002;
  localparam logic [7:0] PIC_BYTE_RESET = 8'h00;
  localparam logic PIC_OUT_RESET = 1'b1;

  typedef enum logic [2:0] {
    PIC_MODE_TERM    = 3'b000,
    PIC_MODE_ONESHOT = 3'b001,
    PIC_MODE_RATE    = 3'b010,
    PIC_MODE_SQUARE  = 3'b011,
    PIC_MODE_SWSTB   = 3'b100,
    PIC_MODE_HWSTB   = 3'b101,
    PIC_MODE_RSVD6   = 3'b110,
    PIC_MODE_RSVD7   = 3'b111
  } pic_mode_t;
endpackage : pic_pkg
`default_nettype wire
